/* File: inc/fpesp_pkg.sv */
// Constants and types for the parallel NOR program/erase host controller
package fpesp_pkg;

  // Bus widths of the x16 array
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;

  // Clock and pin timing, figures in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WP_NS = 35;     // Write strobe low
  localparam int T_WPH_NS = 20;    // Write strobe high between cycles
  localparam int T_ACC_NS = 105;   // Address/strobe to output valid
  localparam int T_OPH_NS = 20;    // Output enable high between reads
  localparam int T_BUSY_NS = 90;   // Command valid to busy pin low
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPH_CYC = (T_OPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command sequence lengths in write cycles
  localparam int PROG_CYCLES = 4;
  localparam int ERASE_CYCLES = 6;

  // Unlock and setup codes of the command sequences
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 26'h0000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 26'h00002AA;
  localparam logic [DATA_W-1:0] UNLOCK_CODE_A = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_CODE_B = 16'h0055;
  localparam logic [DATA_W-1:0] PROG_SETUP_CODE = 16'h00A0;
  localparam logic [DATA_W-1:0] ERASE_SETUP_CODE = 16'h0080;
  localparam logic [ADDR_W-1:0] CHIP_ERASE_ADDR = 26'h0000555;
  localparam logic [DATA_W-1:0] CHIP_ERASE_CODE = 16'h0010;
  localparam logic [DATA_W-1:0] BLOCK_ERASE_CODE = 16'h0030;

  // Status bit positions
  localparam int CPL_BIT = 7;   // completion_polarity_bit
  localparam int TGL_BIT = 6;   // toggle_progress_bit
  localparam int ETGL_BIT = 2;  // erase_toggle_bit

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_CHIP_ERASE,
    OP_BLOCK_ERASE
  } fpesp_op_t;

  // User request
  typedef struct packed {
    fpesp_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpesp_req_t;

  // Driven flash pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [DATA_W-1:0] dq_out;
  } fpesp_pins_t;

endpackage

/* File: hw/fpesp_host.sv */
// Host controller issuing program/erase sequences and polling for completion
// Operation
// - Chip erase ends with a write of 10h to word address 555h.
// - Block erase ends with a write of 30h to the block address.
// - Program is four write cycles; the last carries target address and word.
// - Host polls completion bit before reading the programmed word back.
`timescale 1ns/1ps
module fpesp_host (
  input wire logic clock,                          // 25 MHz clock
  input wire logic arst_n,                         // Async reset, low
  input wire logic req_valid,                      // Request present
  output logic req_ready,                          // Controller idle
  input wire fpesp_pkg::fpesp_req_t req,           // Operation, addr, word
  output logic done,                               // Operation finished
  output logic [fpesp_pkg::DATA_W-1:0] rdata,      // Final word read
  output logic busy,                               // Operation running
  output fpesp_pkg::fpesp_pins_t pins,             // Flash pin drive
  input wire logic [fpesp_pkg::DATA_W-1:0] dq_in,  // Flash data in
  input wire logic ready_busy_n                    // Flash ready, high
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_BUSY, ST_RSET, ST_RACC, ST_RGAP
  } fpesp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data of one command write cycle
  function automatic logic [fpesp_pkg::ADDR_W+fpesp_pkg::DATA_W-1:0]
      cmd_cycle(fpesp_pkg::fpesp_req_t r, logic [2:0] step);
    logic [fpesp_pkg::ADDR_W+fpesp_pkg::DATA_W-1:0] v;
    v = {fpesp_pkg::UNLOCK_ADDR_A, fpesp_pkg::UNLOCK_CODE_A};
    case (step)
      3'h1, 3'h4: v = {fpesp_pkg::UNLOCK_ADDR_B, fpesp_pkg::UNLOCK_CODE_B};
      3'h2: begin
        if (r.op == fpesp_pkg::OP_PROGRAM) begin
          v = {fpesp_pkg::UNLOCK_ADDR_A, fpesp_pkg::PROG_SETUP_CODE};
        end else begin
          v = {fpesp_pkg::UNLOCK_ADDR_A, fpesp_pkg::ERASE_SETUP_CODE};
        end
      end
      3'h3: begin
        if (r.op == fpesp_pkg::OP_PROGRAM) begin
          v = {r.addr, r.data};
        end
      end
      3'h5: begin
        if (r.op == fpesp_pkg::OP_CHIP_ERASE) begin
          v = {fpesp_pkg::CHIP_ERASE_ADDR, fpesp_pkg::CHIP_ERASE_CODE};
        end else begin
          v = {r.addr, fpesp_pkg::BLOCK_ERASE_CODE};
        end
      end
      default: v = {fpesp_pkg::UNLOCK_ADDR_A, fpesp_pkg::UNLOCK_CODE_A};
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  fpesp_state_t state_ff, nxt_state;
  fpesp_pkg::fpesp_req_t req_ff, nxt_req;
  fpesp_pkg::fpesp_pins_t pins_ff, nxt_pins;
  logic [2:0] step_ff, nxt_step;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [fpesp_pkg::DATA_W-1:0] prev_ff, nxt_prev;
  logic have_prev_ff, nxt_have_prev;
  logic polled_ff, nxt_polled;
  logic finish_ff, nxt_finish;
  logic done_ff, nxt_done;
  logic [fpesp_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;

  logic is_prog;
  logic last_step;
  logic sample;
  logic cpl_ok;
  logic stable;
  logic [fpesp_pkg::DATA_W-1:0] poll_word;

  assign is_prog = (req_ff.op == fpesp_pkg::OP_PROGRAM);
  assign last_step = is_prog ? (step_ff == 3'(fpesp_pkg::PROG_CYCLES - 1))
                             : (step_ff == 3'(fpesp_pkg::ERASE_CYCLES - 1));
  assign sample = (state_ff == ST_RACC) && (cnt_ff == 4'h0);
  // Erased cells read one, so erase expects a one on the polarity bit
  assign cpl_ok = is_prog ? (dq_in[fpesp_pkg::CPL_BIT] ==
                             req_ff.data[fpesp_pkg::CPL_BIT])
                          : dq_in[fpesp_pkg::CPL_BIT];
  // Two equal reads in a row mean the toggling has stopped
  assign stable = have_prev_ff &&
      (dq_in[fpesp_pkg::TGL_BIT] == prev_ff[fpesp_pkg::TGL_BIT]) &&
      (is_prog || (dq_in[fpesp_pkg::ETGL_BIT] ==
                   prev_ff[fpesp_pkg::ETGL_BIT]));

  // Next state of the whole sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_pins = pins_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    nxt_prev = prev_ff;
    nxt_have_prev = have_prev_ff;
    nxt_polled = polled_ff;
    nxt_finish = finish_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    poll_word = {fpesp_pkg::DATA_W{1'b0}};
    case (state_ff)
      ST_IDLE: begin
        if (req_valid) begin
          nxt_req = req;
          nxt_step = 3'h0;
          nxt_have_prev = 1'b0;
          nxt_polled = 1'b0;
          nxt_finish = 1'b0;
          nxt_state = ST_WSET;
          {nxt_pins.addr, nxt_pins.dq_out} = cmd_cycle(req, 3'h0);
          nxt_pins.dq_oe = 1'b1;
          nxt_pins.ce_n = 1'b0;
        end
      end
      ST_WSET: begin
        // Address held from before the strobe falls
        nxt_pins.we_n = 1'b0;
        nxt_cnt = 4'(fpesp_pkg::WP_CYC - 1);
        nxt_state = ST_WLOW;
      end
      ST_WLOW: begin
        if (cnt_ff == 4'h0) begin
          nxt_pins.we_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_cnt = 4'(fpesp_pkg::WPH_CYC - 1);
          nxt_state = ST_WHIGH;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_WHIGH: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (last_step) begin
          // Give the device time to drop its busy pin first
          nxt_pins.dq_oe = 1'b0;
          nxt_cnt = 4'(fpesp_pkg::BUSY_CYC - 1);
          nxt_state = ST_BUSY;
        end else begin
          nxt_step = step_ff + 3'h1;
          {nxt_pins.addr, nxt_pins.dq_out} = cmd_cycle(req_ff, step_ff + 3'h1);
          nxt_pins.ce_n = 1'b0;
          nxt_state = ST_WSET;
        end
      end
      ST_BUSY: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_RSET;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_RSET: begin
        nxt_pins.addr = (req_ff.op == fpesp_pkg::OP_CHIP_ERASE) ?
                        fpesp_pkg::CHIP_ERASE_ADDR : req_ff.addr;
        nxt_pins.ce_n = 1'b0;
        nxt_pins.oe_n = 1'b0;
        nxt_cnt = 4'(fpesp_pkg::ACC_CYC - 1);
        nxt_state = ST_RACC;
      end
      ST_RACC: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          poll_word = dq_in;
          nxt_prev = poll_word;
          nxt_have_prev = 1'b1;
          if (polled_ff) begin
            nxt_rdata = poll_word;
            nxt_finish = 1'b1;
          end else if (cpl_ok && stable && ready_busy_n) begin
            // Program needs one clean read after status settles
            nxt_polled = is_prog;
            nxt_finish = !is_prog;
            nxt_rdata = poll_word;
          end
          nxt_pins.oe_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_cnt = 4'(fpesp_pkg::OPH_CYC - 1);
          nxt_state = ST_RGAP;
        end
      end
      ST_RGAP: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (finish_ff) begin
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_state = ST_RSET;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      pins_ff <= '{addr: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                   dq_oe: 1'b0, dq_out: '0};
      step_ff <= 3'h0;
      cnt_ff <= 4'h0;
      prev_ff <= '0;
      have_prev_ff <= 1'b0;
      polled_ff <= 1'b0;
      finish_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      pins_ff <= nxt_pins;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
      prev_ff <= nxt_prev;
      have_prev_ff <= nxt_have_prev;
      polled_ff <= nxt_polled;
      finish_ff <= nxt_finish;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign req_ready = (state_ff == ST_IDLE);
  assign busy = (state_ff != ST_IDLE);
  assign done = done_ff;
  assign rdata = rdata_ff;
  assign pins = pins_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [2:0] wr_cnt_ff;
  logic [1:0] rd_cnt_ff;

  // Strobe and read counters for the checks only
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_cnt_ff <= 3'h0;
      rd_cnt_ff <= 2'h0;
    end else if (state_ff == ST_IDLE) begin
      wr_cnt_ff <= 3'h0;
      rd_cnt_ff <= 2'h0;
    end else begin
      if (state_ff == ST_WSET) begin
        wr_cnt_ff <= wr_cnt_ff + 3'h1;
      end
      if (sample && rd_cnt_ff != 2'h3) begin
        rd_cnt_ff <= rd_cnt_ff + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_ff);

  sequence s_quiet_bus;
    (pins.oe_n && pins.ce_n) [*3];
  endsequence

  a_strobe_pair: assert property (!pins.we_n |-> !pins.ce_n)
    else $error("write strobe low without chip select");
  a_program_len: assert property ($rose(state_ff == ST_BUSY) && is_prog
      |-> wr_cnt_ff == 3'h4)
    else $error("program did not issue four write cycles");
  a_erase_len: assert property ($rose(state_ff == ST_BUSY) && !is_prog
      |-> wr_cnt_ff == 3'h6)
    else $error("erase did not issue six write cycles");
  a_chip_erase_last: assert property (state_ff == ST_WLOW && last_step &&
      req_ff.op == fpesp_pkg::OP_CHIP_ERASE
      |-> pins.addr == 26'h0000555 && pins.dq_out == 16'h0010)
    else $error("chip erase last cycle wrong");
  a_block_erase_last: assert property (state_ff == ST_WLOW && last_step &&
      req_ff.op == fpesp_pkg::OP_BLOCK_ERASE
      |-> pins.addr == req_ff.addr && pins.dq_out == 16'h0030)
    else $error("block erase last cycle wrong");
  a_busy_wait: assert property ($rose(state_ff == ST_BUSY)
      |-> s_quiet_bus)
    else $error("status read began before busy delay");
  a_poll_first: assert property (done && is_prog
      |-> rd_cnt_ff == 2'h3)
    else $error("program read back without status polling");
  a_cpl_wait: assert property (sample && !polled_ff && !cpl_ok
      |=> !finish_ff && !polled_ff)
    else $error("finished while polarity bit showed busy");
  a_toggle_wait: assert property (sample && !polled_ff &&
      dq_in[6] != prev_ff[6] |=> !finish_ff && !polled_ff)
    else $error("finished while progress bit toggled");
  a_erase_toggle: assert property (sample && !polled_ff && !is_prog &&
      dq_in[2] != prev_ff[2] |=> !finish_ff)
    else $error("erase finished while erase bit toggled");
  a_true_data: assert property (sample && !polled_ff && !is_prog &&
      !dq_in[7] |=> !finish_ff)
    else $error("erase finished without true data on polarity bit");
  a_no_contention: assert property (!pins.oe_n |-> !pins.dq_oe)
    else $error("data driven while flash outputs enabled");

endmodule

/* File: sim/fpesp_flash_model.sv */
// Behavioural parallel NOR flash answering commands and status polls
`timescale 1ns/1ps
module fpesp_flash_model (
  input wire fpesp_pkg::fpesp_pins_t pins, // Host pin drive
  input wire logic [7:0] busy_reads, // Status reads before finishing
  output logic [15:0] dq_in, // Data toward host
  output logic ready_busy_n, // Ready pin, high when idle
  output logic dev_busy // Operation running inside
);
  logic [15:0] mem [int];
  logic [2:0] step;
  logic is_prog;
  logic [15:0] pd;
  logic tgl;
  logic etgl;
  logic [7:0] cnt;
  logic [15:0] held;
  logic [25:0] wr_addr;
  logic armed;

  ////////////////////////////////////////////////////////////////////////
  // Unwritten words read as erased
  function automatic logic [15:0] rd_mem(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Busy pin drops at once, well inside the allowed delay
  task automatic start(input logic p, input logic [15:0] d);
    dev_busy = 1'b1;
    ready_busy_n = 1'b0;
    is_prog = p;
    pd = d;
    cnt = 8'h00;
    if (busy_reads == 8'h00) begin
      dev_busy = 1'b0;
      ready_busy_n = 1'b1;
    end
  endtask

  initial begin
    step = 3'h0;
    dev_busy = 1'b0;
    ready_busy_n = 1'b1;
    tgl = 1'b0;
    etgl = 1'b0;
    held = 16'h0000;
    dq_in = 16'h0000;
    armed = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address taken at the strobe fall while selected
  always @(negedge pins.we_n) begin
    armed = !pins.ce_n && !dev_busy;
    wr_addr = pins.addr;
  end

  // Data taken at the strobe rise, so a host that moves it early is caught
  always @(posedge pins.we_n) begin
    if (armed) begin
      armed = 1'b0;
      case (step)
        3'h0: step = (wr_addr == 26'h555 && pins.dq_out == 16'hAA) ? 1 : 0;
        3'h1: step = (wr_addr == 26'h2AA && pins.dq_out == 16'h55) ? 2 : 0;
        3'h2: step = (wr_addr != 26'h555) ? 0 :
                     (pins.dq_out == 16'hA0) ? 3 :
                     (pins.dq_out == 16'h80) ? 4 : 0;
        3'h3: begin
          // Programming only clears bits
          mem[wr_addr] = rd_mem(wr_addr) & pins.dq_out;
          start(1'b1, pins.dq_out);
          step = 0;
        end
        3'h4: step = (wr_addr == 26'h555 && pins.dq_out == 16'hAA) ? 5 : 0;
        3'h5: step = (wr_addr == 26'h2AA && pins.dq_out == 16'h55) ? 6 : 0;
        default: begin
          if (wr_addr == 26'h555 && pins.dq_out == 16'h10) begin
            foreach (mem[k]) mem[k] = 16'hFFFF;
            start(1'b0, 16'h0000);
          end else if (pins.dq_out == 16'h30) begin
            foreach (mem[k])
              if (k / 65536 == wr_addr / 65536) mem[k] = 16'hFFFF;
            start(1'b0, 16'h0000);
          end
          step = 0;
        end
      endcase
    end
  end

  // End of each read: status bits advance, released bus shows no stale data
  always @(posedge pins.oe_n) begin
    held = ~dq_in;
    if (dev_busy) begin
      tgl = ~tgl;
      if (!is_prog) etgl = ~etgl;
      cnt = cnt + 8'h01;
      if (cnt >= busy_reads) begin
        dev_busy = 1'b0;
        ready_busy_n = 1'b1;
      end
    end
  end

  // Read data: status while busy, array contents afterwards
  always @(pins.ce_n, pins.oe_n, pins.addr, dev_busy, tgl, etgl, held) begin
    if (pins.ce_n || pins.oe_n) dq_in = held;
    else if (dev_busy) begin
      dq_in = 16'h0000;
      dq_in[7] = is_prog ? ~pd[7] : 1'b0;
      dq_in[6] = tgl;
      dq_in[2] = etgl;
    end else dq_in = rd_mem(pins.addr);
  end
endmodule

/* File: sim/fpesp_host_tb.sv */
// Self-checking bench for the program/erase host controller
`timescale 1ns/1ps
module fpesp_host_tb;
  logic clock;
  logic arst_n;
  logic req_valid;
  logic req_ready;
  fpesp_pkg::fpesp_req_t req;
  logic done;
  logic [15:0] rdata;
  logic busy;
  fpesp_pkg::fpesp_pins_t pins;
  logic [15:0] dq_in;
  logic ready_busy_n;
  logic [7:0] busy_reads;
  logic dev_busy;
  logic [25:0] wa [$];
  logic [15:0] wd [$];
  int bad_count;
  int checked;
  int reads;

  fpesp_host i_dut (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .rdata(rdata),
    .busy(busy), .pins(pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n));

  fpesp_flash_model i_flash (.pins(pins), .busy_reads(busy_reads),
    .dq_in(dq_in), .ready_busy_n(ready_busy_n), .dev_busy(dev_busy));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Record every write cycle; data must be driven while strobed
  always @(negedge pins.we_n) begin
    if (pins.ce_n === 1'b0) begin
      wa.push_back(pins.addr);
      wd.push_back(pins.dq_out);
      check(pins.dq_oe, 1'b1);
    end
  end

  // Every finished read, status polls and readback alike
  always @(posedge pins.oe_n) reads++;

  ////////////////////////////////////////////////////////////////////////
  // One request: command cycles, completion and final word are judged
  task automatic run_op(input fpesp_pkg::fpesp_op_t op, input logic [25:0] a,
      input logic [15:0] d, input logic [7:0] n, input logic [15:0] exp);
    int k;
    logic [41:0] ex [$];
    logic saw_busy;
    wa.delete();
    wd.delete();
    reads = 0;
    busy_reads <= n;
    req <= '{op: op, addr: a, data: d};
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    req_valid <= 1'b0;
    check(done, 1'b0);
    k = 0;
    saw_busy = 1'b0;
    do begin
      @(posedge clock);
      k++;
      saw_busy = saw_busy | busy;
    end while (done !== 1'b1 && k < 5000);
    check(done, 1'b1);
    check(busy, 1'b0);
    check(saw_busy, 1'b1);
    check(reads > n + (op == fpesp_pkg::OP_PROGRAM), 1'b1);
    check(rdata, exp);
    check(dev_busy, 1'b0);
    ex = '{{26'h555, 16'hAA}, {26'h2AA, 16'h55}};
    if (op == fpesp_pkg::OP_PROGRAM) begin
      ex.push_back({26'h555, 16'hA0});
      ex.push_back({a, d});
    end else begin
      ex.push_back({26'h555, 16'h80});
      ex.push_back({26'h555, 16'hAA});
      ex.push_back({26'h2AA, 16'h55});
      if (op == fpesp_pkg::OP_CHIP_ERASE) ex.push_back({26'h555, 16'h10});
      else ex.push_back({a, 16'h30});
    end
    check(wa.size(), ex.size());
    foreach (ex[i]) check({wa[i], wd[i]}, ex[i]);
  endtask

  // Device done at once, written bit 7 high
  task automatic prog_fast;
    run_op(fpesp_pkg::OP_PROGRAM, 26'h0000100, 16'h00A5, 8'h00, 16'h00A5);
  endtask

  // Long busy, top address, written bit 7 low
  task automatic prog_slow;
    run_op(fpesp_pkg::OP_PROGRAM, 26'h3FFFFFF, 16'h1234, 8'h06, 16'h1234);
  endtask

  // Reprogramming only clears bits, readback shows the merge
  task automatic prog_overwrite;
    run_op(fpesp_pkg::OP_PROGRAM, 26'h0000100, 16'h0F0F, 8'h02, 16'h0005);
  endtask

  // Block erase polled at a written word of that block
  task automatic erase_block;
    run_op(fpesp_pkg::OP_BLOCK_ERASE, 26'h0000100, 16'h0000, 8'h04,
      16'hFFFF);
  endtask

  // Erased word takes new data
  task automatic prog_after_erase;
    run_op(fpesp_pkg::OP_PROGRAM, 26'h0000100, 16'h5A5A, 8'h01, 16'h5A5A);
  endtask

  // Chip erase, polled at the fixed address
  task automatic erase_chip;
    run_op(fpesp_pkg::OP_CHIP_ERASE, 26'h0000000, 16'h0000, 8'h03,
      16'hFFFF);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard: ops take well under a thousand cycles each
  initial begin
    #400000;
    bad_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end

  initial begin
    bad_count = 0;
    checked = 0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    busy_reads = 8'h00;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    prog_fast();
    prog_slow();
    prog_overwrite();
    erase_block();
    prog_after_erase();
    erase_chip();
    stop_test();
  end
endmodule
